// ---- rtl/loader_pkg.sv ----
/*
 * shared constants and types for the serial file loader.
 * assumes one system clock at sixteen times the serial bit rate.
 */
package loader_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LEN_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned OFS_W = 3;
    localparam int unsigned SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // receiver timing, in clock cycles
    // ------------------------------------------------------------
    localparam int unsigned START_COUNTS = 8;
    localparam int unsigned BIT_COUNTS = 16;
    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_COUNTS - 1);
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_COUNTS - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [OFS_W-1:0] OFS_ZERO = 3'h0;
    localparam logic [OFS_W-1:0] OFS_ONE = 3'h1;
    localparam logic [OFS_W-1:0] OFS_LAST = 3'h7;

    // ------------------------------------------------------------
    // engine and bus constants
    // ------------------------------------------------------------
    localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam int unsigned CPU_SEL_BIT = 15;

    // ------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_MARK = 2'b00,
        RX_DATA = 2'b01,
        RX_STOP = 2'b10,
        RX_ERR = 2'b11
    } rx_state_type;

    typedef enum logic [1:0] {
        ENG_HIGH = 2'b00,
        ENG_LOW = 2'b01,
        ENG_DOWNLOAD = 2'b10,
        ENG_HANDOFF = 2'b11
    } eng_state_type;

endpackage : loader_pkg

// ---- rtl/byte_stream_if.sv ----
/*
 * byte stream carrier with valid and ready handshake.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface byte_stream_if;
    import loader_pkg::*;
    logic valid;
    logic ready;
    logic [DATA_W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : byte_stream_if

// ---- rtl/serial_byte_receiver.sv ----
/*
 * asynchronous serial byte receiver, four states.
 * assumes rx_in is already synchronised to clk_in.
 */
`timescale 1ns/10ps
module serial_byte_receiver
    import loader_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic rx_in,
    byte_stream_if.source byte_out,
    output logic rx_error_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        rx_state_type state;
        logic [CNT_W-1:0] cnt;
        logic [OFS_W-1:0] offset;
        logic [DATA_W-1:0] hold;
        logic low_seen;
        logic taken;
    } rx_regs_type;

    rx_regs_type r;
    rx_regs_type next_r;

    always_comb begin
        next_r = r;
        unique case (r.state)
            RX_MARK: begin
                next_r.taken = 1'b0;
                if (rx_in) begin
                    next_r.cnt = CNT_ZERO;
                end else if (r.cnt == START_LAST) begin
                    next_r.state = RX_DATA;
                    next_r.cnt = CNT_ZERO;
                    next_r.offset = OFS_ZERO;
                end else begin
                    next_r.cnt = r.cnt + CNT_ONE;
                end
            end
            RX_DATA: begin
                if (r.cnt == BIT_LAST) begin
                    next_r.hold[r.offset] = rx_in;
                    next_r.offset = r.offset + OFS_ONE;
                    next_r.cnt = CNT_ZERO;
                    if (r.offset == OFS_LAST) begin
                        next_r.state = RX_STOP;
                        next_r.low_seen = 1'b0;
                    end
                end else begin
                    next_r.cnt = r.cnt + CNT_ONE;
                end
            end
            RX_STOP: begin
                if (byte_out.ready && !r.taken) begin
                    next_r.taken = 1'b1;
                end
                if (r.low_seen) begin
                    if (rx_in) begin
                        next_r.state = RX_MARK;
                        next_r.cnt = CNT_ZERO;
                    end
                end else if (r.cnt == BIT_LAST) begin
                    next_r.cnt = CNT_ZERO;
                    if (rx_in) begin
                        next_r.state = RX_ERR;
                    end else begin
                        next_r.low_seen = 1'b1;
                    end
                end else begin
                    next_r.cnt = r.cnt + CNT_ONE;
                end
            end
            RX_ERR: begin
                next_r = r;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign byte_out.valid = (r.state == RX_STOP) && !r.taken;
    assign byte_out.data = r.hold;
    assign rx_error_out = (r.state == RX_ERR);

endmodule : serial_byte_receiver

// ---- rtl/two_entry_buffer.sv ----
/*
 * two-entry byte buffer with valid and ready on both sides.
 * assumes source and sink share clk_in.
 */
`timescale 1ns/10ps
module two_entry_buffer
    import loader_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    byte_stream_if.sink fill,
    byte_stream_if.source drain
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][DATA_W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } buf_regs_type;

    buf_regs_type r;
    buf_regs_type next_r;
    logic push;
    logic pop;

    assign fill.ready = (r.count != 2'h2);
    assign drain.valid = (r.count != 2'h0);
    assign drain.data = r.mem[r.rd_ptr];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr_ptr] = fill.data;
            next_r.wr_ptr = !r.wr_ptr;
        end
        if (pop) begin
            next_r.rd_ptr = !r.rd_ptr;
        end
        if (push && !pop) begin
            next_r.count = r.count + 2'h1;
        end else if (pop && !push) begin
            next_r.count = r.count - 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule : two_entry_buffer

// ---- rtl/serial_upgrade_file_loader.sv ----
/*
 * serial file loader: receiver, buffer, control engine and bus
 * handover unit writing a length-prefixed file into scratch ram.
 * assumes a single clock at sixteen times the bit rate; pins are
 * asynchronous and pass two flip-flops before use.
 */
`timescale 1ns/10ps
module serial_upgrade_file_loader
    import loader_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic optical_rx_input_in,
    input wire logic [DATA_W-1:0] ram_data_in,
    output logic [DATA_W-1:0] ram_data_out,
    output logic ram_data_oe_out,
    output logic [ADDR_W-1:0] ram_addr_out,
    output logic ram_write_n_out,
    output logic ram_select_n_out,
    input wire logic [ADDR_W-1:0] cpu_address_bus_in,
    input wire logic cpu_read_strobe_n_in,
    input wire logic program_store_qualifier_in,
    output logic [DATA_W-1:0] cpu_data_out,
    output logic cpu_data_oe_out,
    output logic irq_out,
    output logic rx_error_out,
    output logic [1:0] engine_state_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rx;
        logic sel;
        logic read_n;
        logic qual;
        logic [DATA_W-1:0] ram;
    } pin_set_type;

    pin_set_type sync_a;
    pin_set_type sync_b;
    pin_set_type pin_now;

    assign pin_now.rx = optical_rx_input_in;
    assign pin_now.sel = cpu_address_bus_in[CPU_SEL_BIT];
    assign pin_now.read_n = cpu_read_strobe_n_in;
    assign pin_now.qual = program_store_qualifier_in;
    assign pin_now.ram = ram_data_in;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // idle levels, so no false start or read follows reset
            sync_a <= '0;
            sync_a.rx <= 1'b1;
            sync_a.read_n <= 1'b1;
            sync_b <= '0;
            sync_b.rx <= 1'b1;
            sync_b.read_n <= 1'b1;
        end else begin
            sync_a <= pin_now;
            sync_b <= sync_a;
        end
    end

    // ------------------------------------------------------------
    // receiver and buffer
    // ------------------------------------------------------------
    byte_stream_if rx_stream ();
    byte_stream_if eng_stream ();
    logic rx_error;

    serial_byte_receiver receiver (
        .clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .rx_in(sync_b.rx),
        .byte_out(rx_stream.source),
        .rx_error_out(rx_error)
    );

    two_entry_buffer byte_buffer (
        .clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .fill(rx_stream.sink),
        .drain(eng_stream.source)
    );

    // ------------------------------------------------------------
    // control engine and bus handover unit
    // ------------------------------------------------------------
    typedef struct packed {
        eng_state_type state;
        logic [LEN_W-1:0] length_count;
        logic [ADDR_W-1:0] add_cntr;
        logic writing;
        logic [DATA_W-1:0] ram_data;
        logic ram_oe;
        logic write_n;
        logic select_n;
        logic [DATA_W-1:0] cpu_data;
        logic cpu_oe;
        logic irq;
        logic rx_error;
    } eng_regs_type;

    eng_regs_type r;
    eng_regs_type next_r;
    logic take;
    logic cpu_read;

    assign eng_stream.ready = !r.writing;
    assign take = eng_stream.valid && eng_stream.ready;
    assign cpu_read = sync_b.qual && sync_b.sel && !sync_b.read_n;

    always_comb begin
        next_r = r;
        next_r.rx_error = rx_error;
        unique case (r.state)
            ENG_HIGH: begin
                if (take) begin
                    next_r.length_count = {eng_stream.data,
                        r.length_count[DATA_W-1:0]};
                    next_r.state = ENG_LOW;
                end
            end
            ENG_LOW: begin
                if (take) begin
                    next_r.length_count = {r.length_count[LEN_W-1:DATA_W],
                        eng_stream.data};
                    if ({r.length_count[LEN_W-1:DATA_W], eng_stream.data}
                        == LEN_ZERO) begin
                        next_r.state = ENG_HANDOFF;
                    end else begin
                        next_r.state = ENG_DOWNLOAD;
                    end
                end
            end
            ENG_DOWNLOAD: begin
                if (r.writing) begin
                    next_r.writing = 1'b0;
                    next_r.write_n = 1'b1;
                    next_r.add_cntr = r.add_cntr + ADDR_ONE;
                    next_r.length_count = r.length_count - LEN_ONE;
                    if (r.length_count == LEN_ONE) begin
                        next_r.state = ENG_HANDOFF;
                    end
                end else if (take) begin
                    next_r.writing = 1'b1;
                    next_r.ram_data = eng_stream.data;
                    next_r.write_n = 1'b0;
                end
            end
            ENG_HANDOFF: begin
                next_r.writing = 1'b0;
            end
        endcase

        // bus handover decided from next engine state, and cpu_oe also from the synchronised cpu read
        next_r.irq = (next_r.state == ENG_HANDOFF);
        next_r.ram_oe = (next_r.state == ENG_DOWNLOAD);
        next_r.cpu_oe = (next_r.state == ENG_HANDOFF) && cpu_read;
        next_r.select_n = !next_r.cpu_oe;
        next_r.cpu_data = next_r.cpu_oe ? sync_b.ram : DATA_ZERO;
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r <= '0;
            r.write_n <= 1'b1;
            r.select_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ram_data_out = r.ram_data;
    assign ram_data_oe_out = r.ram_oe;
    assign ram_addr_out = r.add_cntr;
    assign ram_write_n_out = r.write_n;
    assign ram_select_n_out = r.select_n;
    assign cpu_data_out = r.cpu_data;
    assign cpu_data_oe_out = r.cpu_oe;
    assign irq_out = r.irq;
    assign rx_error_out = r.rx_error;
    assign engine_state_out = r.state;

endmodule : serial_upgrade_file_loader

// ---- test/link_far_side.sv ----
/*
 * far side model: serial sender and scratch ram.
 * assumes clk_in runs at sixteen times the bit rate.
 */
`timescale 1ns/10ps
module link_far_side
    import loader_pkg::*;
(
    input wire logic clk_in,
    output logic line_out,
    input wire logic write_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic select_n_in,
    input wire logic [ADDR_W-1:0] cpu_addr_in,
    output logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [0:255];
    logic [DATA_W-1:0] spin = 8'h00;
    initial line_out = 1'b1;
    // ram takes the byte on a low strobe
    always @(posedge clk_in) begin
        spin <= spin + 8'h3b;
        if (!write_n_in) begin
            mem[addr_in[7:0]] <= wdata_in;
        end
    end
    // released ram bus shows a moving pattern
    assign rdata_out = select_n_in ? spin : mem[cpu_addr_in[7:0]];
    // one bit time is sixteen clocks
    task automatic hold_line(input logic lvl);
        line_out = lvl;
        repeat (16) @(posedge clk_in);
        #1;
    endtask : hold_line
    task automatic send_byte(input logic [7:0] d, input logic good);
        @(posedge clk_in);
        #1;
        hold_line(1'b0); // start bit
        for (int i = 0; i < 8; i++) begin
            hold_line(d[i]); // data lsb first, no parity
        end
        hold_line(!good); // stop slot checked low
        hold_line(1'b1);
    endtask : send_byte
endmodule : link_far_side

// ---- test/loader_asserts.sv ----
/*
 * port checker for the serial file loader.
 * assumes one clock and the asynchronous active low reset.
 */
`timescale 1ns/10ps
module loader_asserts
    import loader_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] ram_addr_out,
    input wire logic ram_write_n_out,
    input wire logic ram_select_n_out,
    input wire logic ram_data_oe_out,
    input wire logic cpu_data_oe_out,
    input wire logic irq_out,
    input wire logic rx_error_out,
    input wire logic [1:0] engine_state_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_write_single: assert property ($fell(ram_write_n_out) |=>
        ram_write_n_out) else $error("write strobe too long");
    a_write_download: assert property (!ram_write_n_out |->
        engine_state_out == 2'b10) else $error("write outside download");
    a_addr_step: assert property ($fell(ram_write_n_out) |=>
        ram_addr_out == $past(ram_addr_out) + 16'h0001)
        else $error("address did not step");
    a_addr_still: assert property ($changed(ram_addr_out) |->
        !$past(ram_write_n_out)) else $error("address moved alone");
    a_state_step: assert property ($changed(engine_state_out) |->
        engine_state_out == $past(engine_state_out) + 2'b01
        || engine_state_out == 2'b11) else $error("bad engine step");
    a_download_float: assert property (engine_state_out == 2'b10 |->
        !cpu_data_oe_out) else $error("cpu bus driven in download");
    a_count_float: assert property (engine_state_out < 2'b10
        && $past(engine_state_out) < 2'b10
        |-> !ram_data_oe_out && !cpu_data_oe_out)
        else $error("bus driven in count state");
    a_irq_state: assert property (irq_out |->
        engine_state_out == 2'b11) else $error("irq outside handoff");
    a_irq_soon: assert property (engine_state_out == 2'b11 |->
        ##[0:1] irq_out) else $error("irq missing in handoff");
    a_cpu_handoff: assert property (cpu_data_oe_out |->
        engine_state_out == 2'b11 && !ram_select_n_out)
        else $error("cpu bus driven wrongly");
    a_error_sticky: assert property (rx_error_out |=>
        rx_error_out) else $error("error cleared without reset");
    c_write: cover property ($fell(ram_write_n_out));
    c_irq: cover property ($rose(irq_out));
    c_cpu: cover property ($rose(cpu_data_oe_out));
    c_err: cover property ($rose(rx_error_out));
endmodule : loader_asserts

bind serial_upgrade_file_loader loader_asserts i_loader_asserts (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ram_addr_out(ram_addr_out),
    .ram_write_n_out(ram_write_n_out),
    .ram_select_n_out(ram_select_n_out),
    .ram_data_oe_out(ram_data_oe_out),
    .cpu_data_oe_out(cpu_data_oe_out),
    .irq_out(irq_out),
    .rx_error_out(rx_error_out),
    .engine_state_out(engine_state_out)
);

// ---- test/test_serial_upgrade_file_loader.sv ----
/*
 * testbench for the serial file loader.
 * assumes the far side model and the bound checker.
 */
`timescale 1ns/10ps
module test_serial_upgrade_file_loader;
    import loader_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, line, rdn = 1'b1, qual = 1'b0;
    logic [7:0] rd, wd, cpu_d;
    logic [15:0] addr, cpu_addr = 16'h0000;
    logic ram_oe, wn, seln, cpu_oe, irq, err;
    logic [1:0] st;
    logic [7:0] file [0:2] = '{8'ha5, 8'h3c, 8'h81};
    logic [2:0] combo [0:3] = '{3'b110, 3'b010, 3'b100, 3'b111};
    int fail_count = 0, total_checks = 0;
    serial_upgrade_file_loader i_serial_upgrade_file_loader (
        .ref_clk_in(clk), .nrst_in(nrst), .optical_rx_input_in(line),
        .ram_data_in(rd), .ram_data_out(wd), .ram_data_oe_out(ram_oe),
        .ram_addr_out(addr), .ram_write_n_out(wn),
        .ram_select_n_out(seln), .cpu_address_bus_in(cpu_addr),
        .cpu_read_strobe_n_in(rdn), .program_store_qualifier_in(qual),
        .cpu_data_out(cpu_d), .cpu_data_oe_out(cpu_oe), .irq_out(irq),
        .rx_error_out(err), .engine_state_out(st));
    link_far_side i_link_far_side (
        .clk_in(clk), .line_out(line), .write_n_in(wn), .addr_in(addr),
        .wdata_in(wd), .select_n_in(seln), .cpu_addr_in(cpu_addr),
        .rdata_out(rd));
    initial begin
        forever #5 clk = ~clk;
    end
    // ----
    // tasks
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic do_reset();
        @(posedge clk);
        #1 nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
    endtask : do_reset
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // ----
    // sequence
    // ----
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    initial begin
        do_reset();
        check(16'({st, irq, err, ram_oe, cpu_oe, wn, seln}), 16'h0003);
        check(addr, 16'h0000);
        $display("reset test done");
        i_link_far_side.send_byte(8'h00, 1'b1);
        check(16'(st), 16'h0001);
        i_link_far_side.send_byte(8'h03, 1'b1);
        check(16'({st, ram_oe, cpu_oe}), 16'h000a);
        for (int i = 0; i < 3; i++) begin
            i_link_far_side.send_byte(file[i], 1'b1);
            check(addr, 16'(i + 1));
            check(16'(i_link_far_side.mem[i]), 16'(file[i]));
        end
        check(16'({st, irq}), 16'h0007);
        $display("download test done");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1 {qual, cpu_addr[15], rdn} = combo[k];
            cpu_addr[7:0] = 8'h01;
            repeat (8) @(posedge clk);
            #1;
            check(16'({cpu_oe, seln}), k == 0 ? 16'h0002 : 16'h0001);
            check(16'(cpu_d), k == 0 ? 16'h003c : 16'h0000);
            rdn = 1'b1;
            repeat (8) @(posedge clk);
        end
        i_link_far_side.send_byte(8'h77, 1'b1);
        check(16'({addr[3:0], st}), 16'h000f);
        $display("handoff test done");
        do_reset();
        i_link_far_side.send_byte(8'h00, 1'b1);
        i_link_far_side.send_byte(8'h00, 1'b1);
        check(16'(st), 16'h0003);
        $display("empty file test done");
        do_reset();
        i_link_far_side.send_byte(8'h55, 1'b0);
        check(16'(err), 16'h0001);
        i_link_far_side.send_byte(8'h12, 1'b1);
        check(16'(err), 16'h0001);
        do_reset();
        check(16'({err, st}), 16'h0000);
        $display("error test done");
        complete_run();
    end
endmodule : test_serial_upgrade_file_loader
